// ===== scdc_pkg.sv
/*
   package for the sample clock delay configuration block: register offsets,
   field layouts, reset values, step limits, mode codes and carrier structs.
   assumes a single 50 MHz clock domain and an 8-bit register port.
*/
package scdc_pkg;

   // ----------------------------------------------------------------
   // bus geometry
   // ----------------------------------------------------------------
   localparam int SCDC_ADDR_W = 12;
   localparam int SCDC_DATA_W = 8;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] SCDC_OFS_PHASE = 12'h10b;
   localparam logic [11:0] SCDC_OFS_MODE = 12'h110;
   localparam logic [11:0] SCDC_OFS_SUPER = 12'h111;
   localparam logic [11:0] SCDC_OFS_FINE = 12'h112;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] SCDC_RST_MODE = 3'h0;
   localparam logic [7:0] SCDC_RST_SUPER = 8'h00;
   localparam logic [7:0] SCDC_RST_FINE = 8'hc0;
   localparam logic [3:0] SCDC_RST_PHASE = 4'h0;

   // ----------------------------------------------------------------
   // field widths and step limits
   // ----------------------------------------------------------------
   localparam int SCDC_MODE_W = 3;
   localparam int SCDC_PHASE_W = 4;
   localparam int SCDC_STEP_W = 8;
   localparam int SCDC_MODE_PAD_W = SCDC_DATA_W - SCDC_MODE_W;
   localparam int SCDC_PHASE_PAD_W = SCDC_DATA_W - SCDC_PHASE_W;
   localparam logic [7:0] SCDC_FINE_SHORT_MAX = 8'h10;
   localparam logic [7:0] SCDC_FINE_FULL_MAX = 8'hc0;
   localparam logic [7:0] SCDC_SUPER_MAX = 8'h80;
   localparam logic [7:0] SCDC_STEPS_ZERO = 8'h00;
   localparam logic [1:0] SCDC_SKEW_ZERO = 2'h0;

   // step sizes in femtoseconds, for reference by users of the outputs
   localparam int SCDC_FINE_STEP_FS = 1725;
   localparam int SCDC_SUPER_STEP_FS = 250;

   // ----------------------------------------------------------------
   // delay mode codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SCDC_MODE_NONE = 3'b000,
      SCDC_MODE_FINE_SHORT = 3'b010,
      SCDC_MODE_FINE_LOWJIT = 3'b011,
      SCDC_MODE_FINE_FULL = 3'b100,
      SCDC_MODE_FINE_SUPER = 3'b110
   } scdc_mode_type;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic fine_en;
      logic superfine_en;
      logic lowest_jitter;
      logic [7:0] fine_steps;
      logic [7:0] superfine_steps;
   } scdc_delay_type;

   typedef struct packed {
      logic window_en;
      logic [1:0] neg_skew;
      logic [1:0] pos_skew;
   } scdc_skew_type;

endpackage

// ===== scdc_sync3.sv
/*
   three-stage synchroniser with agreement filter for one pin level.
   assumes din is asynchronous to clk; level follows once stages two and
   three agree, rise pulses for one cycle on a low-to-high change.
*/
module scdc_sync3
   import scdc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic din,
   output logic level,
   output logic rise
);

   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         level <= 1'b0;
         rise <= 1'b0;
      end
      else
      begin
         rise <= (s2_reg == s3_reg) && s3_reg && !level;
         if (s2_reg == s3_reg)
         begin
            level <= s3_reg;
         end
      end
   end

endmodule

// ===== scdc_mode_decode.sv
/*
   combinational decode of the delay mode into applied fine and superfine
   settings. assumes step values are already saturated by the register bank.
*/
module scdc_mode_decode
   import scdc_pkg::*;
(
   input wire logic [2:0] mode,
   input wire logic [7:0] fine,
   input wire logic [7:0] superfine,
   output scdc_delay_type delay
);

   always_comb
   begin
      delay = '0;
      case (scdc_mode_type'(mode))
         SCDC_MODE_FINE_SHORT:
         begin
            delay.fine_en = 1'b1;
            delay.superfine_en = 1'b1;
            delay.fine_steps = (fine > SCDC_FINE_SHORT_MAX) ? SCDC_FINE_SHORT_MAX : fine;
            delay.superfine_steps = superfine;
         end
         SCDC_MODE_FINE_LOWJIT:
         begin
            delay.fine_en = 1'b1;
            delay.lowest_jitter = 1'b1;
            delay.fine_steps = (fine > SCDC_FINE_SHORT_MAX) ? SCDC_FINE_SHORT_MAX : fine;
         end
         SCDC_MODE_FINE_FULL:
         begin
            delay.fine_en = 1'b1;
            delay.fine_steps = fine;
         end
         SCDC_MODE_FINE_SUPER:
         begin
            delay.fine_en = 1'b1;
            delay.superfine_en = 1'b1;
            delay.fine_steps = fine;
            delay.superfine_steps = superfine;
         end
         default:
         begin
            delay = '0;
         end
      endcase
   end

endmodule

// ===== scdc_top.sv
/*
   register bank for the sample clock delay path: mode select, fine and
   superfine adjust, and the divider phase captured at the sync event.
   assumes a plain register port with one-cycle strobes, read data in the
   following cycle, skew-window controls and phase status from device logic
   on the same clock, and an asynchronous sync pin.
*/
// Notes on behaviour
// - report captured divider phase, four bits
// - phase status meaningful only with window enabled
// - zero windows: phase equals phase status bits
// - three-bit mode select, resets to no delay
// - mode 010: fine delay, 0 to 16
// - mode 011: lowest jitter fine, 0 to 16
// - mode 100: fine delay, full 192 steps
// - mode 110: fine 192 plus superfine 128
// - eight-bit superfine value, resets zero, max 128
// - superfine used only in modes 010, 110
// - eight-bit fine value, 1.725 ps per step
// - fine used only in modes 2,3,4,6
// - fine range 0 to 192, resets 192
module scdc_top
   import scdc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [11:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic sync_pin,
   input wire scdc_skew_type skew_cfg,
   input wire logic [3:0] divider_phase,
   input wire logic [7:0] sync_phase_status,
   output scdc_delay_type delay_out,
   output logic phase_valid,
   output logic [3:0] phase_offset
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [2:0] mode_reg;
   logic [7:0] super_reg;
   logic [7:0] fine_reg;
   logic [3:0] phase_reg;
   logic [7:0] rdata_next;
   logic sync_level;
   logic sync_rise;
   logic windows_zero;
   logic [3:0] phase_next;
   scdc_delay_type delay_next;

   // ----------------------------------------------------------------
   // sync pin
   // ----------------------------------------------------------------
   scdc_sync3 u_sync
   (
      .clk(clk),
      .rstn(rstn),
      .din(sync_pin),
      .level(sync_level),
      .rise(sync_rise)
   );

   // ----------------------------------------------------------------
   // mode register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mode_reg <= SCDC_RST_MODE;
      end
      else if (wr && (addr == SCDC_OFS_MODE))
      begin
         mode_reg <= wdata[SCDC_MODE_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // superfine adjust register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         super_reg <= SCDC_RST_SUPER;
      end
      else if (wr && (addr == SCDC_OFS_SUPER))
      begin
         // saturate at the top step
         super_reg <= (wdata > SCDC_SUPER_MAX) ? SCDC_SUPER_MAX : wdata;
      end
   end

   // ----------------------------------------------------------------
   // fine adjust register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         fine_reg <= SCDC_RST_FINE;
      end
      else if (wr && (addr == SCDC_OFS_FINE))
      begin
         // out-of-range writes clamp rather than wrap
         fine_reg <= (wdata > SCDC_FINE_FULL_MAX) ? SCDC_FINE_FULL_MAX : wdata;
      end
   end

   // ----------------------------------------------------------------
   // divider phase capture
   // ----------------------------------------------------------------
   assign windows_zero = (skew_cfg.neg_skew == SCDC_SKEW_ZERO) &&
                         (skew_cfg.pos_skew == SCDC_SKEW_ZERO);

   always_comb
   begin
      if (windows_zero)
      begin
         phase_next = sync_phase_status[SCDC_PHASE_W-1:0];
      end
      else
      begin
         phase_next = divider_phase;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         phase_reg <= SCDC_RST_PHASE;
      end
      else if (sync_rise && skew_cfg.window_en)
      begin
         phase_reg <= phase_next;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         phase_valid <= 1'b0;
         phase_offset <= SCDC_RST_PHASE;
      end
      else
      begin
         phase_valid <= skew_cfg.window_en;
         phase_offset <= phase_reg;
      end
   end

   // ----------------------------------------------------------------
   // applied delay
   // ----------------------------------------------------------------
   scdc_mode_decode u_decode
   (
      .mode(mode_reg),
      .fine(fine_reg),
      .superfine(super_reg),
      .delay(delay_next)
   );

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         delay_out <= '0;
      end
      else
      begin
         delay_out <= delay_next;
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   always_comb
   begin
      rdata_next = '0;
      if (rd)
      begin
         case (addr)
            SCDC_OFS_MODE: rdata_next = {{SCDC_MODE_PAD_W{1'b0}}, mode_reg};
            SCDC_OFS_SUPER: rdata_next = super_reg;
            SCDC_OFS_FINE: rdata_next = fine_reg;
            SCDC_OFS_PHASE: rdata_next = {{SCDC_PHASE_PAD_W{1'b0}}, phase_reg};
            default: rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rdata <= '0;
      end
      else
      begin
         rdata <= rdata_next;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_mode_write;
      wr && (addr == SCDC_OFS_MODE);
   endsequence

   sequence s_direct_capture;
      sync_rise && skew_cfg.window_en && windows_zero;
   endsequence

   a_mode_write_takes: assert property (@(posedge clk) disable iff (!rstn)
      s_mode_write |=> (mode_reg == $past(wdata[2:0])))
      else $error("mode register did not take write");

   a_mode_readback_pad: assert property (@(posedge clk) disable iff (!rstn)
      (rd && (addr == SCDC_OFS_MODE)) |=> (rdata == {5'h00, $past(mode_reg)}))
      else $error("mode readback wrong or reserved bits set");

   a_rdata_idle_zero: assert property (@(posedge clk) disable iff (!rstn)
      !rd |=> (rdata == 8'h00))
      else $error("read data not zero outside read");

   a_unlisted_mode_none: assert property (@(posedge clk) disable iff (!rstn)
      ((mode_reg == 3'h1) || (mode_reg == 3'h5) || (mode_reg == 3'h7) ||
       (mode_reg == 3'h0)) |=> (delay_out == '0))
      else $error("unlisted mode applied delay");

   a_fine_gate_modes: assert property (@(posedge clk) disable iff (!rstn)
      delay_out.fine_en |-> ($past(mode_reg) inside {3'h2, 3'h3, 3'h4, 3'h6}))
      else $error("fine delay enabled in wrong mode");

   a_short_fine_limit: assert property (@(posedge clk) disable iff (!rstn)
      ($past(mode_reg) inside {3'h2, 3'h3}) |->
      (delay_out.fine_steps <= 8'h10) &&
      (($past(fine_reg) > 8'h10) || (delay_out.fine_steps == $past(fine_reg))))
      else $error("short fine range not honoured");

   a_lowjit_flag: assert property (@(posedge clk) disable iff (!rstn)
      (delay_out.lowest_jitter == ($past(mode_reg) == 3'h3)) &&
      (!delay_out.lowest_jitter || !delay_out.superfine_en))
      else $error("lowest jitter flag mismatched");

   a_full_fine_range: assert property (@(posedge clk) disable iff (!rstn)
      ($past(mode_reg) == 3'h4) |->
      (delay_out.fine_en && !delay_out.superfine_en &&
       (delay_out.fine_steps == $past(fine_reg))))
      else $error("full fine mode wrong");

   a_fine_super_both: assert property (@(posedge clk) disable iff (!rstn)
      ($past(mode_reg) == 3'h6) |->
      (delay_out.fine_en && delay_out.superfine_en &&
       (delay_out.fine_steps == $past(fine_reg)) &&
       (delay_out.superfine_steps == $past(super_reg))))
      else $error("combined delay mode wrong");

   a_super_gate_modes: assert property (@(posedge clk) disable iff (!rstn)
      delay_out.superfine_en |-> ($past(mode_reg) inside {3'h2, 3'h6}))
      else $error("superfine enabled in wrong mode");

   a_super_saturate: assert property (@(posedge clk) disable iff (!rstn)
      (wr && (addr == SCDC_OFS_SUPER)) |=>
      (super_reg == (($past(wdata) > 8'h80) ? 8'h80 : $past(wdata))))
      else $error("superfine write not saturated at 128");

   a_fine_saturate: assert property (@(posedge clk) disable iff (!rstn)
      (wr && (addr == SCDC_OFS_FINE)) |=>
      (fine_reg == (($past(wdata) > 8'hc0) ? 8'hc0 : $past(wdata))) ##0 (fine_reg <= 8'hc0))
      else $error("fine write not saturated at 192");

   a_fine_readback: assert property (@(posedge clk) disable iff (!rstn)
      (rd && (addr == SCDC_OFS_FINE)) |=> (rdata == $past(fine_reg)))
      else $error("fine readback wrong");

   a_phase_direct: assert property (@(posedge clk) disable iff (!rstn)
      s_direct_capture |=> (phase_reg == $past(sync_phase_status[3:0]))
      ##1 (phase_offset == $past(phase_reg)))
      else $error("direct phase capture wrong");

   a_phase_hold: assert property (@(posedge clk) disable iff (!rstn)
      !(sync_rise && skew_cfg.window_en) |=> $stable(phase_reg))
      else $error("phase changed without enabled sync event");

   a_phase_valid_flag: assert property (@(posedge clk) disable iff (!rstn)
      ##1 (phase_valid == $past(skew_cfg.window_en)))
      else $error("phase valid does not follow window enable");

   a_phase_window_cap: assert property (@(posedge clk) disable iff (!rstn)
      (sync_rise && skew_cfg.window_en && !windows_zero) |=>
      (phase_reg == $past(divider_phase)))
      else $error("divider phase not captured");

   a_mode_hold: assert property (@(posedge clk) disable iff (!rstn)
      !(wr && (addr == SCDC_OFS_MODE)) |=> $stable(mode_reg))
      else $error("mode register changed without write");

   a_super_hold: assert property (@(posedge clk) disable iff (!rstn)
      !(wr && (addr == SCDC_OFS_SUPER)) |=> $stable(super_reg))
      else $error("superfine register changed without write");

   a_fine_hold: assert property (@(posedge clk) disable iff (!rstn)
      !(wr && (addr == SCDC_OFS_FINE)) |=> $stable(fine_reg))
      else $error("fine register changed without write");

   a_super_off_zero: assert property (@(posedge clk) disable iff (!rstn)
      !delay_out.superfine_en |-> (delay_out.superfine_steps == 8'h00))
      else $error("superfine steps applied while disabled");

   a_fine_off_zero: assert property (@(posedge clk) disable iff (!rstn)
      !delay_out.fine_en |-> (delay_out.fine_steps == 8'h00))
      else $error("fine steps applied while disabled");

   a_short_super: assert property (@(posedge clk) disable iff (!rstn)
      ($past(mode_reg) == 3'h2) |->
      (delay_out.superfine_en && (delay_out.superfine_steps == $past(super_reg))))
      else $error("superfine not applied in short fine mode");

   a_super_readback: assert property (@(posedge clk) disable iff (!rstn)
      (rd && (addr == SCDC_OFS_SUPER)) |=> (rdata == $past(super_reg)))
      else $error("superfine readback wrong");

   a_phase_readback: assert property (@(posedge clk) disable iff (!rstn)
      (rd && (addr == SCDC_OFS_PHASE)) |=> (rdata == {4'h0, $past(phase_reg)}))
      else $error("phase readback wrong or reserved bits set");

   a_rise_single: assert property (@(posedge clk) disable iff (!rstn)
      sync_rise |-> sync_level ##1 !sync_rise)
      else $error("sync event without agreed level or longer than one cycle");

   a_offset_follows: assert property (@(posedge clk) disable iff (!rstn)
      ##1 (phase_offset == $past(phase_reg)))
      else $error("phase offset does not follow captured phase");

endmodule

// ===== tb_top.sv
/*
   self-checking testbench for the sample clock delay register bank:
   register port, delay mode decode and sync phase capture.
   assumes scdc_pkg and scdc_top are compiled first and one 50 MHz clock.
*/
module tb_top
   import scdc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk;
   logic rstn;
   logic [11:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic sync_pin;
   scdc_skew_type skew_cfg;
   logic [3:0] divider_phase;
   logic [7:0] sync_phase_status;
   scdc_delay_type delay_out;
   logic phase_valid;
   logic [3:0] phase_offset;
   int n_errors;
   int n_compared;

   scdc_top scdc_top_i (
      .clk(clk),
      .rstn(rstn),
      .addr(addr),
      .wdata(wdata),
      .wr(wr),
      .rd(rd),
      .rdata(rdata),
      .sync_pin(sync_pin),
      .skew_cfg(skew_cfg),
      .divider_phase(divider_phase),
      .sync_phase_status(sync_phase_status),
      .delay_out(delay_out),
      .phase_valid(phase_valid),
      .phase_offset(phase_offset)
   );

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read data sampled in the cycle after the strobe only
   task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic sync_pulse();
      @(posedge clk);
      sync_pin <= 1'b1;
      repeat (4) @(posedge clk);
      sync_pin <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
   endtask

   function automatic scdc_delay_type expect_delay(input int m, input logic [7:0] f,
                                                   input logic [7:0] s);
      scdc_delay_type e;
      logic [7:0] fc;
      e = '0;
      fc = (f > 8'h10) ? 8'h10 : f;
      e.fine_en = (m == 2 || m == 3 || m == 4 || m == 6);
      e.superfine_en = (m == 2 || m == 6);
      e.lowest_jitter = (m == 3);
      if (e.fine_en)
         e.fine_steps = (m < 4) ? fc : f;
      if (e.superfine_en)
         e.superfine_steps = s;
      return e;
   endfunction

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic test_regs();
      logic [7:0] d;
      check(32'(delay_out), 32'h0, "delay after reset");
      rd_reg(SCDC_OFS_MODE, d);
      check(32'(d), 32'h00, "mode reset");
      rd_reg(SCDC_OFS_SUPER, d);
      check(32'(d), 32'h00, "superfine reset");
      rd_reg(SCDC_OFS_FINE, d);
      check(32'(d), 32'hc0, "fine reset");
      @(posedge clk);
      #1;
      check(32'(rdata), 32'h00, "read data lingers");
      rd_reg(SCDC_OFS_PHASE, d);
      check(32'(d), 32'h00, "phase reset");
      wr_reg(SCDC_OFS_FINE, 8'h00);
      rd_reg(SCDC_OFS_FINE, d);
      check(32'(d), 32'h00, "fine low end");
      wr_reg(SCDC_OFS_SUPER, 8'h9a);
      rd_reg(SCDC_OFS_SUPER, d);
      check(32'(d), 32'h80, "superfine above range");
      wr_reg(SCDC_OFS_MODE, 8'hff);
      rd_reg(SCDC_OFS_MODE, d);
      check(32'(d), 32'h07, "mode reserved bits");
      wr_reg(12'h113, 8'h5a);
      rd_reg(12'h113, d);
      check(32'(d), 32'h00, "unmapped read");
   endtask

   task automatic test_modes();
      logic [7:0] fines [2] = '{8'h11, 8'hc0};
      logic [7:0] sups [2] = '{8'h80, 8'h07};
      for (int k = 0; k < 2; k++)
      begin
         wr_reg(SCDC_OFS_FINE, fines[k]);
         wr_reg(SCDC_OFS_SUPER, sups[k]);
         for (int m = 0; m < 8; m++)
         begin
            wr_reg(SCDC_OFS_MODE, 8'(m));
            @(posedge clk);
            #1;
            check(32'(delay_out), 32'(expect_delay(m, fines[k], sups[k])), "decode");
         end
      end
      wr_reg(SCDC_OFS_MODE, 8'h00);
   endtask

   task automatic test_sync();
      logic [7:0] d;
      // window fields change only while the pin is idle
      @(posedge clk);
      skew_cfg <= '{window_en: 1'b1, neg_skew: 2'h0, pos_skew: 2'h0};
      sync_phase_status <= 8'ha5;
      divider_phase <= 4'h3;
      sync_pulse();
      check(32'(phase_valid), 32'h1, "phase valid");
      check(32'(phase_offset), 32'h5, "zero window phase");
      rd_reg(SCDC_OFS_PHASE, d);
      check(32'(d), 32'h05, "phase readback");
      @(posedge clk);
      skew_cfg <= '{window_en: 1'b1, neg_skew: 2'h1, pos_skew: 2'h0};
      sync_pulse();
      check(32'(phase_offset), 32'h3, "divider phase");
      @(posedge clk);
      skew_cfg <= '{window_en: 1'b0, neg_skew: 2'h1, pos_skew: 2'h0};
      divider_phase <= 4'h9;
      sync_pulse();
      check(32'(phase_valid), 32'h0, "phase not valid");
      check(32'(phase_offset), 32'h3, "disabled capture");
      wr_reg(SCDC_OFS_PHASE, 8'hff);
      rd_reg(SCDC_OFS_PHASE, d);
      check(32'(d), 32'h03, "phase read only");
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial
   begin
      n_errors = 0;
      n_compared = 0;
      rstn = 1'b0;
      addr = 12'h000;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      sync_pin = 1'b0;
      skew_cfg = '0;
      divider_phase = 4'h0;
      sync_phase_status = 8'h00;
      repeat (12) @(posedge clk);
      #1;
      check(32'(delay_out), 32'h0, "delay in reset");
      check(32'(phase_offset), 32'h0, "phase in reset");
      @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      #1;
      test_regs();
      test_modes();
      test_sync();
      summarize();
   end

   initial
   begin
      #200000;
      n_errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      summarize();
   end
endmodule
